/* src/flash_cyc_if.sv */
// one flash bus cycle request between sequencer and pin driver
`timescale 1ns/1ps
interface flash_cyc_if;
    logic        req;
    logic        wr;
    logic [17:0] addr;
    logic [15:0] wdata;
    logic        done;
    logic [15:0] rdata;
    modport ctrl (output req, output wr, output addr, output wdata,
                  input done, input rdata);
    modport pins (input req, input wr, input addr, input wdata,
                  output done, output rdata);
endinterface

/* src/flash_host.sv */
// host controller that drives a parallel boot-sector flash over its pins
//
// Overview of operation
// - high-voltage identify: host raises bit nine and sets bits 6, 1, 0
// - bit 6 low; bits 1:0 00 maker, 01 device, 10 protect with sector
// - program starts only after unlock cycles; host issues them first
// - while lockout holds the host keeps control pins inactive
// - host writes reset command to leave in-system identification
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_host (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        SRST,
    // register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    // flash address and control pins
    output logic      [16:0] FL_A,
    output logic             FL_CE_N,
    output logic             FL_OE_N,
    output logic             FL_WE_N,
    output logic             FL_BYTE_N,
    // flash data pins
    output logic      [15:0] FL_DQ_O,
    output logic      [15:0] FL_DQ_OE,
    input  wire logic [15:0] FL_DQ_I,
    // high-voltage requests and supply lockout
    output logic             FL_HV_ID,
    output logic             FL_RST_HV,
    input  wire logic        SUPPLY_LOCKOUT
);
    typedef enum logic [2:0] {
        S_IDLE, S_UNLOCK_A, S_UNLOCK_B, S_COMMAND, S_DATA, S_READ, S_FINISH
    } seq_state_t;

    flash_cyc_if cyc ();

    seq_state_t              st;
    seq_state_t              next_st;
    flash_host_pkg::op_t     op;
    logic [17:0]             addr_reg;
    logic [15:0]             wdata_reg;
    logic [15:0]             rdata_reg;
    logic [3:0]              cfg;
    logic [1:0]              id_sel;
    logic                    busy;
    logic                    protected_flag;
    logic                    refused;
    logic                    lockout_seen;
    logic                    issued;
    logic [2:0]              sector_select;
    logic                    wr_ctrl;
    logic                    wr_addr;
    logic                    wr_wdata;
    logic                    wr_cfg;
    logic                    start;
    logic                    step_wr;
    logic [17:0]             step_addr;
    logic [15:0]             step_data;
    logic [17:0]             id_addr;
    logic [17:0]             id_offset;
    logic                    hv_id;
    logic [31:0]             status_word;
    logic [31:0]             next_rdata;
    logic [16:0]             pin_a;
    logic                    pin_ce_n;
    logic                    pin_oe_n;
    logic                    pin_we_n;
    logic [15:0]             pin_dq_o;
    logic [15:0]             pin_dq_oe;

    // register decode
    assign wr_ctrl  = WR && ADDR == `REG_CTRL;
    assign wr_addr  = WR && ADDR == `REG_ADDR;
    assign wr_wdata = WR && ADDR == `REG_WDATA;
    assign wr_cfg   = WR && ADDR == `REG_CONFIG;
    // no new order while lockout holds: the flash would drop it anyway
    assign start    = wr_ctrl && !busy && !SUPPLY_LOCKOUT;

    flash_sector_decode u_decode (
        .top_boot      (cfg[`CFG_TOP]),
        .hi_addr       (addr_reg[17:13]),
        .sector_select (sector_select)
    );

    // identification addresses in A16..A-1 units: a word offset n and a
    // byte offset 2n land on the same pins, so one table serves both
    assign hv_id     = cfg[`CFG_HV_ID];
    assign id_offset = (id_sel == `ID_MAKER)  ? 18'h00000 :
                       (id_sel == `ID_DEVICE) ? 18'h00002 :
                                                18'h00004;
    // bit 6 stays low; sector bits only for the protect read
    assign id_addr = (id_sel == `ID_PROTECT)
                     ? {addr_reg[17:`SECT_LSB], 13'h0000} | id_offset
                     : id_offset;

    // cycle contents per step of the sequence
    assign step_wr   = st != S_READ;
    assign step_addr = (st == S_UNLOCK_A) ? `UNLOCK_A_ADDR :
                       (st == S_UNLOCK_B) ? `UNLOCK_B_ADDR :
                       (st == S_READ && op == flash_host_pkg::OP_ID_READ)
                                          ? id_addr : addr_reg;
    assign step_data = (st == S_UNLOCK_A) ? `UNLOCK_A_DATA :
                       (st == S_UNLOCK_B) ? `UNLOCK_B_DATA :
                       (st == S_DATA)     ? wdata_reg :
                       (op == flash_host_pkg::OP_PROGRAM) ? `CMD_PROGRAM :
                       (op == flash_host_pkg::OP_IDENT)   ? `CMD_IDENT :
                       (op == flash_host_pkg::OP_RESET)   ? `CMD_RESET :
                                                            wdata_reg;

    always_comb begin
        next_st = st;
        case (st)
            S_IDLE: begin
                if (start) begin
                    case (flash_host_pkg::op_t'(WDATA[2:0]))
                        flash_host_pkg::OP_READ:    next_st = S_READ;
                        flash_host_pkg::OP_ID_READ: next_st = S_READ;
                        flash_host_pkg::OP_WRITE:   next_st = S_DATA;
                        flash_host_pkg::OP_RESET:   next_st = S_COMMAND;
                        flash_host_pkg::OP_PROGRAM: next_st = S_UNLOCK_A;
                        flash_host_pkg::OP_IDENT:   next_st = S_UNLOCK_A;
                        default:                    next_st = S_IDLE;
                    endcase
                end
            end
            S_UNLOCK_A: next_st = cyc.done ? S_UNLOCK_B : st;
            S_UNLOCK_B: next_st = cyc.done ? S_COMMAND : st;
            S_COMMAND: begin
                if (cyc.done) begin
                    next_st = (op == flash_host_pkg::OP_PROGRAM)
                              ? S_DATA : S_FINISH;
                end
            end
            S_DATA:   next_st = cyc.done ? S_FINISH : st;
            S_READ:   next_st = cyc.done ? S_FINISH : st;
            S_FINISH: next_st = S_IDLE;
            default:  next_st = S_IDLE;
        endcase
        if (SUPPLY_LOCKOUT) begin
            next_st = S_IDLE;
        end
    end

    flash_pin_driver u_pins (
        .clk       (CLK),
        .srst      (SRST),
        .word_mode (cfg[`CFG_WORD]),
        .abort     (SUPPLY_LOCKOUT),
        .cyc       (cyc.pins),
        .a         (pin_a),
        .ce_n      (pin_ce_n),
        .oe_n      (pin_oe_n),
        .we_n      (pin_we_n),
        .dq_o      (pin_dq_o),
        .dq_oe     (pin_dq_oe),
        .dq_i      (FL_DQ_I)
    );

    // one request per step; issued drops when the step's cycle is done
    assign cyc.req   = st != S_IDLE && st != S_FINISH && !issued
                       && !SUPPLY_LOCKOUT;
    assign cyc.wr    = step_wr;
    assign cyc.addr  = step_addr;
    assign cyc.wdata = step_data;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            st             <= S_IDLE;
            issued         <= 1'b0;
            op             <= flash_host_pkg::OP_READ;
            id_sel         <= `ID_MAKER;
            busy           <= 1'b0;
            addr_reg       <= 18'h00000;
            wdata_reg      <= 16'h0000;
            cfg            <= 4'h1;
        end else begin
            st     <= next_st;
            issued <= cyc.req ? 1'b1 : (cyc.done ? 1'b0 : issued);
            if (SUPPLY_LOCKOUT) begin
                issued <= 1'b0;
            end
            busy   <= next_st != S_IDLE;
            if (start) begin
                op     <= flash_host_pkg::op_t'(WDATA[2:0]);
                id_sel <= WDATA[4:3];
            end
            if (wr_addr) begin
                addr_reg <= WDATA[17:0];
            end
            if (wr_wdata) begin
                wdata_reg <= WDATA[15:0];
            end
            if (wr_cfg && !busy) begin
                cfg <= WDATA[3:0];
            end
        end
    end

    // results and sticky flags; a new fault wins over a clearing write
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rdata_reg      <= 16'h0000;
            protected_flag <= 1'b0;
            refused        <= 1'b0;
            lockout_seen   <= 1'b0;
        end else begin
            if (st == S_READ && cyc.done) begin
                rdata_reg <= cyc.rdata;
                if (op == flash_host_pkg::OP_ID_READ
                    && id_sel == `ID_PROTECT) begin
                    protected_flag <= cyc.rdata[7:0] != `LOW_BYTE_ZERO;
                end
            end
            refused      <= (wr_ctrl && (busy || SUPPLY_LOCKOUT))
                            || (refused && !(wr_ctrl && WDATA[31]));
            lockout_seen <= SUPPLY_LOCKOUT
                            || (lockout_seen && !(wr_ctrl && WDATA[30]));
        end
    end

    assign status_word = {20'h00000, 1'b0, sector_select, lockout_seen,
                          refused, protected_flag, SUPPLY_LOCKOUT,
                          1'b0, st};
    assign next_rdata  = (ADDR == `REG_ADDR)   ? {14'h0000, addr_reg} :
                         (ADDR == `REG_WDATA)  ? {16'h0000, wdata_reg} :
                         (ADDR == `REG_RDATA)  ? {16'h0000, rdata_reg} :
                         (ADDR == `REG_STATUS) ? status_word :
                         (ADDR == `REG_CONFIG) ? {28'h0000000, cfg} :
                         (ADDR == `REG_CTRL)   ? {27'h0000000, id_sel, op} :
                                                 32'h00000000;

    // top outputs re-registered so every pin comes from a flip-flop here
    always_ff @(posedge CLK) begin
        if (SRST) begin
            RDATA     <= 32'h00000000;
            FL_A      <= 17'h00000;
            FL_CE_N   <= 1'b1;
            FL_OE_N   <= 1'b1;
            FL_WE_N   <= 1'b1;
            FL_BYTE_N <= 1'b1;
            FL_DQ_O   <= 16'h0000;
            FL_DQ_OE  <= 16'h0000;
            FL_HV_ID  <= 1'b0;
            FL_RST_HV <= 1'b0;
        end else begin
            RDATA     <= RD ? next_rdata : 32'h00000000;
            FL_A      <= pin_a;
            FL_CE_N   <= pin_ce_n;
            FL_OE_N   <= pin_oe_n;
            FL_WE_N   <= pin_we_n;
            FL_BYTE_N <= cfg[`CFG_WORD];
            FL_DQ_O   <= pin_dq_o;
            FL_DQ_OE  <= pin_dq_oe;
            // high voltage on bit nine only during a high-voltage id read
            FL_HV_ID  <= hv_id && op == flash_host_pkg::OP_ID_READ
                         && st == S_READ;
            // protected sectors stay writable only while this bit holds
            FL_RST_HV <= cfg[`CFG_TEMP_UNPROT];
        end
    end
endmodule // flash_host

/* src/flash_host_cfg.svh */
// register map, pin timing and command constants of the flash host
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

`define CLK_MHZ         200
`define T_GLITCH_NS     5
`define PULSE_CYC       ((`T_GLITCH_NS * `CLK_MHZ + 999) / 1000 + 1)
`define T_ACCESS_NS     45
`define ACCESS_CYC      ((`T_ACCESS_NS * `CLK_MHZ + 999) / 1000 + 1)

`define REG_CTRL        8'h00
`define REG_ADDR        8'h04
`define REG_WDATA       8'h08
`define REG_RDATA       8'h0C
`define REG_STATUS      8'h10
`define REG_CONFIG      8'h14

`define CFG_WORD        0
`define CFG_TOP         1
`define CFG_HV_ID       2
`define CFG_TEMP_UNPROT 3

`define UNLOCK_A_ADDR   18'h00AAA
`define UNLOCK_A_DATA   16'h00A5
`define UNLOCK_B_ADDR   18'h00554
`define UNLOCK_B_DATA   16'h005A
`define CMD_PROGRAM     16'h00C3
`define CMD_IDENT       16'h0096
`define CMD_RESET       16'h00FF

`define ID_MAKER        2'h0
`define ID_DEVICE       2'h1
`define ID_PROTECT      2'h2
`define SECT_LSB        13
`define LOW_BYTE_ZERO   8'h00
`define MASK_UPPER      16'h00FF

`endif

/* src/flash_host_pkg.sv */
// types shared by the flash host modules
package flash_host_pkg;
    typedef enum logic [2:0] {
        OP_READ, OP_WRITE, OP_PROGRAM, OP_IDENT, OP_RESET, OP_ID_READ
    } op_t;
    typedef enum logic [1:0] {
        CYC_IDLE, CYC_SETUP, CYC_STROBE, CYC_HOLD
    } cyc_state_t;
endpackage

/* src/flash_pin_driver.sv */
// drives one read or write cycle on the flash pins
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_pin_driver (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // mode and abort
    input  wire logic        word_mode,
    input  wire logic        abort,
    // cycle port
    flash_cyc_if.pins        cyc,
    // flash pins
    output logic      [16:0] a,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic      [15:0] dq_o,
    output logic      [15:0] dq_oe,
    input  wire logic [15:0] dq_i
);
    flash_host_pkg::cyc_state_t st;
    logic [7:0]  cnt;
    logic        is_wr;
    logic [15:0] upper_oe;

    // byte width: low byte carries data, bit 15 carries A-1 on writes too
    assign upper_oe = word_mode ? 16'hFFFF : (`MASK_UPPER | 16'h8000);

    always_ff @(posedge clk) begin
        cyc.done <= 1'b0;
        if (srst || abort) begin
            st    <= flash_host_pkg::CYC_IDLE;
            cnt   <= 8'h00;
            is_wr <= 1'b0;
            a     <= 17'h00000;
            ce_n  <= 1'b1;
            oe_n  <= 1'b1;
            we_n  <= 1'b1;
            dq_o  <= 16'h0000;
            dq_oe <= 16'h0000;
            cyc.rdata <= 16'h0000;
        end else begin
            case (st)
                flash_host_pkg::CYC_IDLE: begin
                    if (cyc.req) begin
                        // address changes on the same edge as ce_n and oe_n; we_n falls one cycle later
                        a     <= cyc.addr[17:1];
                        is_wr <= cyc.wr;
                        ce_n  <= 1'b0;
                        oe_n  <= cyc.wr;
                        dq_o  <= word_mode ? cyc.wdata
                                 : {cyc.addr[0], 7'h00, cyc.wdata[7:0]};
                        // never drive data while the flash may output
                        dq_oe <= cyc.wr ? upper_oe
                                 : (word_mode ? 16'h0000 : 16'h8000);
                        st    <= flash_host_pkg::CYC_SETUP;
                    end
                end
                flash_host_pkg::CYC_SETUP: begin
                    we_n <= !is_wr;
                    cnt  <= 8'h00;
                    st   <= flash_host_pkg::CYC_STROBE;
                end
                flash_host_pkg::CYC_STROBE: begin
                    cnt <= cnt + 8'h01;
                    if (is_wr && cnt == 8'(`PULSE_CYC - 1)) begin
                        we_n <= 1'b1;
                        st   <= flash_host_pkg::CYC_HOLD;
                    end else if (!is_wr && cnt == 8'(`ACCESS_CYC - 1)) begin
                        cyc.rdata <= word_mode ? dq_i
                                     : (dq_i & `MASK_UPPER);
                        oe_n <= 1'b1;
                        st   <= flash_host_pkg::CYC_HOLD;
                    end
                end
                flash_host_pkg::CYC_HOLD: begin
                    // data held one cycle past the rising write edge
                    ce_n     <= 1'b1;
                    dq_oe    <= 16'h0000;
                    cyc.done <= 1'b1;
                    st       <= flash_host_pkg::CYC_IDLE;
                end
                default: st <= flash_host_pkg::CYC_IDLE;
            endcase
        end
    end
endmodule // flash_pin_driver

/* src/flash_sector_decode.sv */
// sector number of an address for the top or bottom boot map
`timescale 1ns/1ps
module flash_sector_decode (
    // map choice
    input  wire logic       top_boot,
    // address bits 16 to 12
    input  wire logic [4:0] hi_addr,
    // sector number 0 to 6
    output logic      [2:0] sector_select
);
    logic [2:0] top_sect;
    logic [2:0] bot_sect;

    assign top_sect = (hi_addr[4:3] != 2'b11) ? {1'b0, hi_addr[4:3]} :
                      !hi_addr[2]            ? 3'h3 :
                      hi_addr[1]             ? 3'h6 :
                      (hi_addr[0] ? 3'h5 : 3'h4);
    assign bot_sect = (hi_addr[4:3] != 2'b00) ? 3'h3 + {1'b0, hi_addr[4:3]} :
                      hi_addr[2]             ? 3'h3 :
                      !hi_addr[1]            ? 3'h0 :
                      (hi_addr[0] ? 3'h2 : 3'h1);
    assign sector_select = top_boot ? top_sect : bot_sect;
endmodule // flash_sector_decode

/* testbench/flash_host_bench.sv */
// self-checking bench of the flash host against a flash model
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_host_bench;
    localparam logic [7:0] MAKER = 8'hA3; // arbitrary value
    localparam logic [7:0] DEV   = 8'h6C; // arbitrary value
    localparam logic [7:0] UPPER = 8'h3D; // arbitrary value
    logic        CLK, SRST, WR, RD, SUPPLY_LOCKOUT;
    logic [7:0]  ADDR;
    logic [31:0] WDATA, RDATA, v;
    logic [16:0] FL_A;
    logic        FL_CE_N, FL_OE_N, FL_WE_N, FL_BYTE_N, FL_HV_ID, FL_RST_HV;
    logic [15:0] FL_DQ_O, FL_DQ_OE, FL_DQ_I, dev_q, dev_oe;
    int          err_total = 0;
    int          cmp_count = 0;
    // a line nobody drives shows the inverse of the host's last value
    assign FL_DQ_I = (FL_DQ_OE & FL_DQ_O) | (~FL_DQ_OE & dev_oe & dev_q)
                   | (~FL_DQ_OE & ~dev_oe & ~FL_DQ_O);
    flash_host flash_host_inst (.CLK(CLK), .SRST(SRST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .FL_A(FL_A),
        .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
        .FL_BYTE_N(FL_BYTE_N), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE(FL_DQ_OE),
        .FL_DQ_I(FL_DQ_I), .FL_HV_ID(FL_HV_ID), .FL_RST_HV(FL_RST_HV),
        .SUPPLY_LOCKOUT(SUPPLY_LOCKOUT));
    flash_model #(.MAKER(MAKER), .DEV(DEV), .UPPER(UPPER)) flash_model_inst (
        .a(FL_A), .ce_n(FL_CE_N), .oe_n(FL_OE_N), .we_n(FL_WE_N),
        .byte_n(FL_BYTE_N), .dq(FL_DQ_I), .hv_id(FL_HV_ID),
        .rst_hv(FL_RST_HV), .lockout(SUPPLY_LOCKOUT), .q(dev_q), .q_oe(dev_oe));
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    task automatic complete_run;
        if (err_total == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 500; i++) begin
            reg_rd(`REG_STATUS, v);
            if (v[2:0] === 3'h0)
                return;
        end
        $display("ERROR busy expected 0 seen %h", v[2:0]);
        err_total++;
        complete_run;
    endtask
    task automatic op(input logic [2:0] o, input logic [1:0] s,
                      input logic [17:0] a, input logic [15:0] d);
        reg_wr(`REG_ADDR, {14'h0000, a});
        reg_wr(`REG_WDATA, {16'h0000, d});
        reg_wr(`REG_CTRL, {27'h0000000, s, o});
        wait_idle;
    endtask
    task automatic rd_chk(input string n, input logic [2:0] o,
        input logic [1:0] s, input logic [17:0] a, input logic [31:0] e);
        op(o, s, a, 16'h0000);
        reg_rd(`REG_RDATA, v);
        check(n, e, v);
    endtask
    initial begin
        {SRST, WR, RD, ADDR, WDATA, SUPPLY_LOCKOUT} = {1'b1, 43'h0};
        repeat (2) @(posedge CLK);
        SRST <= 1'b0;
        reg_rd(`REG_CONFIG, v);
        check("config", 32'h1, v);
        reg_rd(8'h20, v);
        check("unmapped", 32'h0, v);
        for (int t = 0; t < 2; t++)
            for (int h = 0; h < 32; h++) begin
                reg_wr(`REG_CONFIG, 32'h1 | (t << 1));
                reg_wr(`REG_ADDR, h << 13);
                reg_rd(`REG_STATUS, v);
                check("sector", {29'h0, flash_model_inst.sect(t[0], h[4:0])},
                      {29'h0, v[10:8]});
            end
        reg_wr(`REG_CONFIG, 32'h1);
        op(3'h2, 2'h0, 18'h00100, 16'h1234);
        rd_chk("word", 3'h0, 2'h0, 18'h00100, 32'h1234);
        op(3'h1, 2'h0, 18'h00100, 16'h0000);
        rd_chk("nounlock", 3'h0, 2'h0, 18'h00100, 32'h1234);
        op(3'h1, 2'h0, `UNLOCK_A_ADDR, `UNLOCK_A_DATA);
        op(3'h1, 2'h0, 18'h00000, `CMD_PROGRAM);
        op(3'h1, 2'h0, 18'h00400, 16'h0000);
        rd_chk("order", 3'h0, 2'h0, 18'h00400, 32'hFFFF);
        reg_wr(`REG_CONFIG, 32'h0);
        rd_chk("byte", 3'h0, 2'h0, 18'h00101, 32'h12);
        op(3'h2, 2'h0, 18'h00203, 16'h005A);
        reg_wr(`REG_CONFIG, 32'h1);
        rd_chk("bytepair", 3'h0, 2'h0, 18'h00202, 32'h5AFF);
        op(3'h3, 2'h0, 18'h00000, 16'h0000);
        rd_chk("maker", 3'h5, 2'h0, 18'h00000, {24'h0, MAKER});
        rd_chk("device", 3'h5, 2'h1, 18'h00002, {16'h0, UPPER, DEV});
        rd_chk("unprot", 3'h5, 2'h2, 18'h10004, 32'h0);
        op(3'h4, 2'h0, 18'h00000, 16'h0000);
        rd_chk("exit", 3'h0, 2'h0, 18'h00100, 32'h1234);
        flash_model_inst.prot[4] = 1'b1;
        op(3'h3, 2'h0, 18'h00000, 16'h0000);
        rd_chk("prot", 3'h5, 2'h2, 18'h10004, 32'h1);
        reg_rd(`REG_STATUS, v);
        check("protflag", 32'h1, {31'h0, v[5]});
        op(3'h4, 2'h0, 18'h00000, 16'h0000);
        op(3'h2, 2'h0, 18'h10000, 16'h00F0);
        rd_chk("locked", 3'h0, 2'h0, 18'h10000, 32'hFFFF);
        reg_wr(`REG_CONFIG, 32'h9);
        op(3'h2, 2'h0, 18'h10000, 16'h00F0);
        rd_chk("temp", 3'h0, 2'h0, 18'h10000, 32'h00F0);
        reg_wr(`REG_CONFIG, 32'h1);
        op(3'h2, 2'h0, 18'h10002, 16'h0F0F);
        rd_chk("relock", 3'h0, 2'h0, 18'h10002, 32'hFFFF);
        reg_wr(`REG_CONFIG, 32'h5);
        rd_chk("hvmaker", 3'h5, 2'h0, 18'h00000, {24'h0, MAKER});
        reg_wr(`REG_CONFIG, 32'h4);
        rd_chk("hvdevice", 3'h5, 2'h1, 18'h00002, {24'h0, DEV});
        reg_wr(`REG_CONFIG, 32'h1);
        @(posedge CLK) SUPPLY_LOCKOUT <= 1'b1;
        reg_wr(`REG_ADDR, 32'h300);
        reg_wr(`REG_CTRL, 32'h2);
        reg_rd(`REG_STATUS, v);
        check("lockout", 32'hF0, v & 32'hF7);
        @(posedge CLK) SUPPLY_LOCKOUT <= 1'b0;
        reg_wr(`REG_CTRL, 32'hC0000000);
        wait_idle;
        check("cleared", 32'h0, {30'h0, v[7:6]});
        rd_chk("nowrite", 3'h0, 2'h0, 18'h00300, 32'hFFFF);
        complete_run;
    end
endmodule // flash_host_bench

/* testbench/flash_host_checker.sv */
// pin assertions of the flash host
`timescale 1ns/1ps
module flash_host_checker (
    // clock and reset
    input wire logic        CLK,
    input wire logic        SRST,
    // flash pins
    input wire logic [16:0] FL_A,
    input wire logic        FL_CE_N,
    input wire logic        FL_OE_N,
    input wire logic        FL_WE_N,
    input wire logic        FL_BYTE_N,
    input wire logic [15:0] FL_DQ_O,
    input wire logic [15:0] FL_DQ_OE,
    input wire logic        FL_HV_ID,
    input wire logic        SUPPLY_LOCKOUT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    AST_NO_FIGHT: assert property (!FL_OE_N |-> FL_DQ_OE[14:0] == 15'h0000
        && (!FL_BYTE_N || !FL_DQ_OE[15]))
        else $error("host drives data while flash outputs on");
    AST_WR_COMBO: assert property (!FL_WE_N |-> !FL_CE_N && FL_OE_N)
        else $error("write strobe without chip select or with gate");
    AST_PULSE: assert property ($fell(FL_WE_N) |=> !FL_WE_N ##1 FL_WE_N)
        else $error("write strobe pulse not two cycles");
    AST_ADDR_HELD: assert property (!FL_WE_N |-> $stable(FL_A))
        else $error("address moved under write strobe");
    AST_DATA_AT_RISE: assert property ($rose(FL_WE_N) |->
        !FL_CE_N && FL_DQ_OE != 16'h0000 && $stable(FL_DQ_O))
        else $error("data not held at write strobe rise");
    AST_BYTE_FLOAT: assert property (!FL_BYTE_N |-> FL_DQ_OE[14:8] == 7'h00)
        else $error("upper data lines driven in byte width");
    AST_HV_ID: assert property (FL_HV_ID |-> FL_WE_N && !FL_A[6])
        else $error("high voltage id with write or bit six high");
    AST_LOCKOUT: assert property (SUPPLY_LOCKOUT && $past(SUPPLY_LOCKOUT) &&
        $past(SUPPLY_LOCKOUT, 2) |-> FL_WE_N && FL_CE_N && FL_DQ_OE == 16'h0000)
        else $error("pins active during supply lockout");
    AST_RESET_IDLE: assert property ($past(SRST) |->
        FL_WE_N && FL_CE_N && FL_OE_N)
        else $error("strobes active right after reset");
endmodule // flash_host_checker
bind flash_host flash_host_checker flash_host_checker_inst (.CLK(CLK),
    .SRST(SRST), .FL_A(FL_A), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N),
    .FL_WE_N(FL_WE_N), .FL_BYTE_N(FL_BYTE_N), .FL_DQ_O(FL_DQ_O),
    .FL_DQ_OE(FL_DQ_OE), .FL_HV_ID(FL_HV_ID), .SUPPLY_LOCKOUT(SUPPLY_LOCKOUT));

/* testbench/flash_model.sv */
// behavioural boot-sector flash on the far side of the host pins
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_model #(
    parameter logic [7:0] MAKER    = 8'hA3, // arbitrary value
    parameter logic [7:0] DEV      = 8'h6C, // arbitrary value
    parameter logic [7:0] UPPER    = 8'h3D, // arbitrary value
    parameter bit         TOP_BOOT = 1'b0,
    parameter int         T_ACC    = 40
) (
    // host pins
    input  wire logic [16:0] a,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        byte_n,
    input  wire logic [15:0] dq,
    input  wire logic        hv_id,
    input  wire logic        rst_hv,
    input  wire logic        lockout,
    // data back to the host
    output logic      [15:0] q,
    output logic      [15:0] q_oe
);
    logic [7:0]  mem [0:262143];
    logic [6:0]  prot = 7'h00;
    logic [2:0]  st = 3'h0;
    logic [17:0] fa;
    logic [15:0] cd, rv;
    realtime     t_fall;
    wire         wstb = !ce_n && !we_n && oe_n;
    wire  [17:0] ra = {a, byte_n ? 1'b0 : dq[15]};

    function automatic logic [2:0] sect(input bit top, input logic [4:0] h);
        if (top)
            return (h[4:3] != 2'h3) ? {1'b0, h[4:3]} :
                !h[2] ? 3'h3 : !h[1] ? 3'h4 + h[0] : 3'h6;
        return (h[4:3] != 2'h0) ? 3'h3 + h[4:3] :
            h[2] ? 3'h3 : h[1] ? 3'h1 + h[0] : 3'h0;
    endfunction

    initial foreach (mem[i]) mem[i] = 8'hFF;
    always @(posedge lockout) st = 3'h0;
    // address at the later falling strobe, data at the earlier rising one
    always @(posedge wstb) begin
        t_fall = $realtime;
        fa = ra;
    end
    always @(negedge wstb) begin
        cd = byte_n ? dq : {8'h00, dq[7:0]};
        if (!lockout && $realtime - t_fall >= 5.0) begin
            if (st == 3'h3) begin
                if (!prot[sect(TOP_BOOT, fa[17:13])] || rst_hv) begin
                    mem[fa] &= cd[7:0];
                    if (byte_n)
                        mem[{fa[17:1], 1'b1}] &= cd[15:8];
                end
                st = 3'h0;
            end else if (fa == `UNLOCK_A_ADDR && cd == `UNLOCK_A_DATA)
                st = 3'h1;
            else if (st == 3'h1 && fa == `UNLOCK_B_ADDR && cd == `UNLOCK_B_DATA)
                st = 3'h2;
            else if (st == 3'h2 && cd == `CMD_PROGRAM)
                st = 3'h3;
            else if (st == 3'h2 && cd == `CMD_IDENT)
                st = 3'h4;
            else
                st = 3'h0;
        end
    end
    always @* begin
        case (a[1:0])
            2'h0: rv = {8'h00, MAKER};
            2'h1: rv = {byte_n ? UPPER : 8'h00, DEV};
            2'h2: rv = {15'h0000, prot[sect(TOP_BOOT, a[16:12])]};
            default: rv = 16'h0000;
        endcase
        if (st != 3'h4 && !hv_id)
            rv = {mem[{ra[17:1], 1'b1}], mem[ra]};
    end
    assign #(T_ACC) q = rv;
    assign q_oe = (!ce_n && !oe_n) ? {byte_n ? 8'hFF : 8'h00, 8'hFF} : 16'h0000;
endmodule // flash_model
